/* File: verilog/power_avg_regs.svh */
`ifndef POWER_AVG_REGS_SVH
`define POWER_AVG_REGS_SVH

`define READING_W       24
`define FACTOR_W        17
`define CORR_W          18

`define OFF_CTRL        8'h00
`define OFF_AVG_COUNT   8'h04
`define OFF_SETTLE      8'h08
`define OFF_NOISE_RATIO 8'h0c
`define OFF_DIGITS      8'h10
`define OFF_DUTY        8'h14
`define OFF_OFFSET      8'h18
`define OFF_FREQ        8'h1c
`define OFF_FILT_RESET  8'h20
`define OFF_STATUS      8'h24

`define CTRL_AVG_EN     0
`define CTRL_AUTO_LO    1
`define CTRL_AUTO_HI    2
`define CTRL_NSR        3
`define CTRL_RUNNING    4
`define CTRL_DCYC_EN    5
`define CTRL_OFS_EN     6

`define AUTO_OFF        2'h0
`define AUTO_ON         2'h1
`define AUTO_ONE_SHOT_AUTO_SELECTION       2'h2

`define RST_AVG_COUNT   17'h00004
`define MAX_AVG_COUNT   17'h10000
`define RST_SETTLE_CS   17'h00190
`define RST_NSR_PPM     20'h02710
`define RST_DIGITS      3'h3
`define MIN_DIGITS      3'h1
`define MAX_DIGITS      3'h4
`define RST_DUTY_MPCT   17'h003e8
`define MIN_DUTY_MPCT   17'h00001
`define MAX_DUTY_MPCT   17'h186a0
`define RST_FREQ_KHZ    32'h00989680
`define DB_PER_LOG2_CDB 32'h0000012d

`endif

/* File: verilog/power_avg_pkg.sv */
package power_avg_pkg;
`include "power_avg_regs.svh"

	typedef enum {S_IDLE, S_DIV, S_OUT} filt_state_t;

	typedef struct packed {
		logic [`READING_W-1:0]     power;
		logic signed [`CORR_W-1:0] corr_cdb;
		logic [31:0]               freq_khz;
		logic [`FACTOR_W-1:0]      length;
	} result_t;

endpackage : power_avg_pkg

/* File: verilog/power_average_correction.sv */
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Functional notes
// RL1: averaging factor settable 1 to 65536, four after reset.
// RL2: factor used only while averaging enabled; otherwise readings pass straight.
// RL3: averaging enable applies to continuous average mode, on after reset.
// RL4: auto mode on keeps applying freshly estimated factors.
// RL5: auto off (reset state) keeps last determined factor fixed.
// RL6: one-shot auto takes one estimate, then holds it fixed.
// RL7: auto criterion is digits target or noise-ratio target; digits after reset.
// RL8: noise-ratio criterion caps factor by settle limit 0.01 to 999.99 s, 4.00.
// RL9: noise-ratio target 100e-6 to 1.00, default 0.01, given to estimator; the register takes any 20-bit ppm value without a range check.
// RL10: digits target 1 to 4, default 3, given to estimator.
// RL11: filter reset drops all stored readings and clears filter state.
// RL12: after filter reset, length grows from 1 up to the factor.
// RL13: every reading shifted in yields a new average over stored readings.
// RL14: running output delivers every new average.
// RL15: block output (reset default) delivers one_shot_auto_selection the filter is refilled.
// RL16: duty correction derives pulse power, duty 0.001 to 100 percent, 1.00.
// RL17: duty correction has its own enable, off after reset.
// RL18: offset correction adds -200 to 200 dB, default 0, when enabled; the register takes any 16-bit cdb value without a range check.
// RL19: negative offsets accepted as well as positive.
// RL20: frequency-response correction uses host frequency, default 10 GHz.
// RL21: duty term is 10*log10(100/duty), added ahead of the level offset.
module power_average_correction
	import power_avg_pkg::*;
#(
	parameter int READINGS_PER_CS = 1
)
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic [2:0]            s_axi_awprot,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	output logic [1:0]                 s_axi_bresp,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic [2:0]            s_axi_arprot,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	input  wire logic                  reading_valid,
	output logic                       reading_ready,
	input  wire logic [`READING_W-1:0] reading,
	input  wire logic                  auto_factor_valid,
	input  wire logic [`FACTOR_W-1:0]  auto_factor,
	output logic                       est_noise_ratio_criterion,
	output logic [2:0]                 est_digits,
	output logic [19:0]                est_noise_ratio_ppm,
	output logic                       result_valid,
	output result_t                    result
);

	logic                 aw_held;
	logic                 w_held;
	logic [7:0]           aw_addr;
	logic [31:0]          w_data;
	logic [3:0]           w_strb;
	logic                 do_write;
	logic                 avg_en;
	logic [1:0]           auto_mode;
	logic                 noise_ratio_criterion;
	logic                 running_output;
	logic                 dcyc_en;
	logic                 ofs_en;
	logic [`FACTOR_W-1:0] factor;
	logic [16:0]          auto_settle_limit;
	logic [19:0]          noise_ratio;
	logic [2:0]           digits;
	logic [16:0]          pulse_duty_percent;
	logic signed [15:0]   offset_cdb;
	logic [31:0]          freq_khz;
	logic                 filt_reset_pend;
	filt_state_t          state;
	logic [`READING_W-1:0] mem [0:`MAX_AVG_COUNT-1];
	logic [15:0]          ptr;
	logic [`FACTOR_W-1:0] len;
	logic [`FACTOR_W-1:0] new_cnt;
	logic [40:0]          sum;
	logic [40:0]          quot;
	logic [17:0]          rem;
	logic [5:0]           div_cnt;
	logic [15:0]          ptr_b;
	logic [`FACTOR_W-1:0] len_b;
	logic [`FACTOR_W-1:0] cnt_b;
	logic [40:0]          sum_b;
	logic [40:0]          next_sum;
	logic [`READING_W-1:0] oldest;
	logic                 take;
	logic                 emit;
	logic [17:0]          rem_sh;
	logic signed [`CORR_W-1:0] next_corr;
	logic [24:0]          settle_cap;
	logic [`FACTOR_W-1:0] capped_auto;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction : merge

	// log2 in 1/16 steps: leading one plus four linear mantissa bits, good to ~0.4 dB from 16 up; below 16 only the leading one is kept
	function automatic logic [8:0] log2_q4(input logic [16:0] x);
		logic [8:0] r;
		r = 9'h000;
		for (int i = 4; i < 17; i++)
			if (x[i])
				r = {i[4:0], x[i-1 -: 4]};
		for (int i = 0; i < 4; i++)
			if (x[i] && x[16:4] == 13'h0000)
				r = {i[4:0], 4'h0};
		return r;
	endfunction : log2_q4

	function automatic logic [16:0] clamp17(input logic [31:0] v, input logic [16:0] lo,
		input logic [16:0] hi);
		if (v < {15'h0000, lo})
			return lo;
		else if (v > {15'h0000, hi})
			return hi;
		return v[16:0];
	endfunction : clamp17

	assign do_write = aw_held && w_held && !s_axi_bvalid;

	// write channel: address and data are taken independently, committed together
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr > `OFF_FILT_RESET || aw_addr[1:0] != 2'h0) ?
					2'h2 : 2'h0;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// read data follows one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			s_axi_rdata <= 32'h00000000;
			if (s_axi_araddr == `OFF_CTRL)
				s_axi_rdata <= {25'h0000000, ofs_en, dcyc_en, running_output,
					noise_ratio_criterion, auto_mode, avg_en};
			else if (s_axi_araddr == `OFF_AVG_COUNT)
				s_axi_rdata <= {15'h0000, factor};
			else if (s_axi_araddr == `OFF_SETTLE)
				s_axi_rdata <= {15'h0000, auto_settle_limit};
			else if (s_axi_araddr == `OFF_NOISE_RATIO)
				s_axi_rdata <= {12'h000, noise_ratio};
			else if (s_axi_araddr == `OFF_DIGITS)
				s_axi_rdata <= {29'h00000000, digits};
			else if (s_axi_araddr == `OFF_DUTY)
				s_axi_rdata <= {15'h0000, pulse_duty_percent};
			else if (s_axi_araddr == `OFF_OFFSET)
				s_axi_rdata <= {{16{offset_cdb[15]}}, offset_cdb};
			else if (s_axi_araddr == `OFF_FREQ)
				s_axi_rdata <= freq_khz;
			else if (s_axi_araddr == `OFF_FILT_RESET)
				s_axi_rdata <= 32'h00000000;
			else if (s_axi_araddr == `OFF_STATUS)
				s_axi_rdata <= {15'h0000, len};
			else
				s_axi_rresp <= 2'h2;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	assign settle_cap = 25'(auto_settle_limit * READINGS_PER_CS);
	assign capped_auto = (noise_ratio_criterion && {8'h00, auto_factor} > settle_cap) ? // RL8
		settle_cap[`FACTOR_W-1:0] : auto_factor;

	// configuration; the factor is written by both software and the estimator
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			avg_en <= 1'b1; // RL3
			auto_mode <= `AUTO_OFF;
			noise_ratio_criterion <= 1'b0; // RL7
			running_output <= 1'b0; // RL15
			dcyc_en <= 1'b0; // RL17
			ofs_en <= 1'b0;
			factor <= `RST_AVG_COUNT; // RL1
			auto_settle_limit <= `RST_SETTLE_CS;
			noise_ratio <= `RST_NSR_PPM; // RL9
			digits <= `RST_DIGITS; // RL10
			pulse_duty_percent <= `RST_DUTY_MPCT; // RL16
			offset_cdb <= 16'h0000;
			freq_khz <= `RST_FREQ_KHZ; // RL20
		end
		else
		begin
			if (auto_factor_valid && auto_mode != `AUTO_OFF) // RL4
			begin
				factor <= clamp17({15'h0000, capped_auto}, 17'h00001, `MAX_AVG_COUNT);
				if (auto_mode == `AUTO_ONE_SHOT_AUTO_SELECTION) // RL6
					auto_mode <= `AUTO_OFF; // RL5
			end
			if (do_write)
			begin
				if (aw_addr == `OFF_CTRL)
				begin
					avg_en <= w_data[`CTRL_AVG_EN]; // RL2
					auto_mode <= (w_data[`CTRL_AUTO_HI:`CTRL_AUTO_LO] == 2'h3) ?
						`AUTO_OFF : w_data[`CTRL_AUTO_HI:`CTRL_AUTO_LO];
					noise_ratio_criterion <= w_data[`CTRL_NSR]; // RL7
					running_output <= w_data[`CTRL_RUNNING]; // RL14
					dcyc_en <= w_data[`CTRL_DCYC_EN]; // RL17
					ofs_en <= w_data[`CTRL_OFS_EN]; // RL18
				end
				else if (aw_addr == `OFF_AVG_COUNT)
					factor <= clamp17(merge({15'h0000, factor}, w_data, w_strb),
						17'h00001, `MAX_AVG_COUNT); // RL1
				else if (aw_addr == `OFF_SETTLE)
					auto_settle_limit <= clamp17(merge({15'h0000, auto_settle_limit}, w_data,
						w_strb), 17'h00001, 17'h1869f); // RL8
				else if (aw_addr == `OFF_NOISE_RATIO)
					noise_ratio <= 20'(merge({12'h000, noise_ratio}, w_data, w_strb)); // RL9
				else if (aw_addr == `OFF_DIGITS && w_data >= 32'(`MIN_DIGITS) &&
					w_data <= 32'(`MAX_DIGITS))
					digits <= w_data[2:0]; // RL10
				else if (aw_addr == `OFF_DUTY)
					pulse_duty_percent <= clamp17(w_data, `MIN_DUTY_MPCT, `MAX_DUTY_MPCT);
				else if (aw_addr == `OFF_OFFSET)
					offset_cdb <= w_data[15:0]; // RL19
				else if (aw_addr == `OFF_FREQ)
					freq_khz <= merge(freq_khz, w_data, w_strb); // RL20
			end
		end
	end

	assign est_noise_ratio_criterion = noise_ratio_criterion;
	assign est_digits = digits;
	assign est_noise_ratio_ppm = noise_ratio;

	// any change of length or bypass restarts the filter; a request during a cycle wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			filt_reset_pend <= 1'b0;
		else if ((do_write && aw_addr == `OFF_FILT_RESET && w_data[0]) ||
			(do_write && aw_addr == `OFF_AVG_COUNT) ||
			(auto_factor_valid && auto_mode != `AUTO_OFF) ||
			(do_write && aw_addr == `OFF_CTRL))
			filt_reset_pend <= 1'b1; // RL11
		else if (state == S_IDLE)
			filt_reset_pend <= 1'b0;
	end

	assign ptr_b = filt_reset_pend ? 16'h0000 : ptr; // RL11
	assign len_b = filt_reset_pend ? 17'h00000 : len;
	assign cnt_b = filt_reset_pend ? 17'h00000 : new_cnt;
	assign sum_b = filt_reset_pend ? 41'h0 : sum;
	assign oldest = mem[ptr_b - factor[15:0]];
	assign take = state == S_IDLE && reading_valid && reading_ready;
	assign next_sum = sum_b + 41'(reading) - ((len_b == factor) ? 41'(oldest) : 41'h0); // RL13
	assign emit = !avg_en || running_output || (cnt_b + 17'h00001 >= factor); // RL15
	assign rem_sh = {rem[16:0], quot[40]};
	assign next_corr = (dcyc_en ? 18'(((log2_q4(`MAX_DUTY_MPCT) - log2_q4(pulse_duty_percent))
		* `DB_PER_LOG2_CDB) >> 4) : 18'h00000) +
		(ofs_en ? 18'(offset_cdb) : 18'h00000); // RL21

	always_ff @(posedge aclk)
	begin
		if (take)
			mem[ptr_b] <= reading;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= S_IDLE;
			reading_ready <= 1'b1;
			ptr <= 16'h0000;
			len <= 17'h00000;
			new_cnt <= 17'h00000;
			sum <= 41'h0;
			quot <= 41'h0;
			rem <= 18'h00000;
			div_cnt <= 6'h00;
			result_valid <= 1'b0;
			result <= '0;
		end
		else
		begin
			result_valid <= 1'b0;
			case (state)
				S_IDLE:
				begin
					ptr <= ptr_b;
					len <= len_b;
					new_cnt <= cnt_b;
					sum <= sum_b;
					if (take && !avg_en)
					begin
						quot <= 41'(reading); // RL2
						len <= 17'h00001;
						state <= S_OUT;
						reading_ready <= 1'b0;
					end
					else if (take)
					begin
						ptr <= ptr_b + 16'h0001;
						len <= (len_b == factor) ? len_b : len_b + 17'h00001; // RL12
						sum <= next_sum;
						quot <= next_sum;
						rem <= 18'h00000;
						div_cnt <= 6'h29;
						new_cnt <= emit ? 17'h00000 : cnt_b + 17'h00001;
						if (emit)
						begin
							state <= S_DIV; // RL14
							reading_ready <= 1'b0;
						end
					end
				end
				S_DIV:
				begin
					// one quotient bit a cycle keeps a 17-bit divisor cheap
					if (rem_sh >= {1'b0, len})
					begin
						rem <= rem_sh - {1'b0, len};
						quot <= {quot[39:0], 1'b1};
					end
					else
					begin
						rem <= rem_sh;
						quot <= {quot[39:0], 1'b0};
					end
					div_cnt <= div_cnt - 6'h01;
					if (div_cnt == 6'h01)
						state <= S_OUT;
				end
				S_OUT:
				begin
					result_valid <= 1'b1;
					result.power <= quot[`READING_W-1:0]; // RL13
					result.corr_cdb <= next_corr; // RL16
					result.freq_khz <= freq_khz; // RL20
					result.length <= len;
					state <= S_IDLE;
					reading_ready <= 1'b1;
				end
				default:
					state <= S_IDLE;
			endcase
		end
	end

	a_bypass_length: assert property (@(posedge aclk) disable iff (!aresetn) // RL2
		result_valid && !avg_en |-> result.length == 17'h00001)
		else $error("bypass result carries a length other than one");
	a_factor_range: assert property (@(posedge aclk) disable iff (!aresetn) // RL1
		factor >= 17'h00001 && factor <= `MAX_AVG_COUNT)
		else $error("averaging factor out of range");
	a_one_shot_auto_selection_returns: assert property (@(posedge aclk) disable iff (!aresetn) // RL6
		auto_factor_valid && auto_mode == `AUTO_ONE_SHOT_AUTO_SELECTION && !do_write
		|=> auto_mode == `AUTO_OFF)
		else $error("one-shot auto selection did not fall back to fixed");
	a_auto_applies: assert property (@(posedge aclk) disable iff (!aresetn) // RL4
		auto_factor_valid && auto_mode == `AUTO_ON && !do_write && !noise_ratio_criterion
		&& auto_factor != 17'h0 && auto_factor <= `MAX_AVG_COUNT
		|=> factor == $past(auto_factor))
		else $error("automatic factor not applied");
	a_fixed_holds: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
		auto_mode == `AUTO_OFF && !do_write |=> factor == $past(factor))
		else $error("fixed factor changed without a write");
	a_settle_cap: assert property (@(posedge aclk) disable iff (!aresetn) // RL8
		auto_factor_valid && auto_mode != `AUTO_OFF && noise_ratio_criterion && !do_write
		|=> {8'h00, factor} <= settle_cap || factor == 17'h00001)
		else $error("auto factor exceeds settle limit");
	// a lowered factor leaves len high until the pending restart clears it
	a_length_bound: assert property (@(posedge aclk) disable iff (!aresetn) // RL12
		avg_en && state == S_IDLE && !filt_reset_pend |-> len <= factor)
		else $error("filter length beyond the factor");
	a_reset_clears: assert property (@(posedge aclk) disable iff (!aresetn) // RL11
		state == S_IDLE && filt_reset_pend && !take |=> len == 17'h0 && sum == 41'h0)
		else $error("filter reset left readings behind");
	a_block_full: assert property (@(posedge aclk) disable iff (!aresetn) // RL15
		result_valid && avg_en && !running_output && !$past(filt_reset_pend, 44)
		|-> result.length == factor)
		else $error("block result before filter refilled");
	// 41 divide steps, one output state, then the registered pulse is seen
	a_result_latency: assert property (@(posedge aclk) disable iff (!aresetn) // RL14
		take && avg_en && emit |-> ##43 result_valid)
		else $error("average not delivered 43 cycles after the reading");
	a_corr_offset: assert property (@(posedge aclk) disable iff (!aresetn) // RL18
		result_valid && ofs_en && !dcyc_en |-> result.corr_cdb == 18'(offset_cdb))
		else $error("offset correction wrong");

	c_running: cover property (@(posedge aclk) result_valid && running_output);
	c_block: cover property (@(posedge aclk) result_valid && !running_output && avg_en);
	c_one_shot_auto_selection: cover property (@(posedge aclk) auto_factor_valid && auto_mode == `AUTO_ONE_SHOT_AUTO_SELECTION);
	c_duty: cover property (@(posedge aclk) result_valid && dcyc_en && ofs_en);

endmodule : power_average_correction

/* File: verif/front_end_model.sv */
`timescale 1ns/100ps
`include "power_avg_regs.svh"
module front_end_model
(
	input  wire logic             aclk,
	input  wire logic             reading_ready,
	output logic                  reading_valid,
	output logic [`READING_W-1:0] reading,
	output logic                  auto_factor_valid,
	output logic [`FACTOR_W-1:0]  auto_factor
);
	initial
	begin
		reading_valid = 1'b0;
		reading = '0;
		auto_factor_valid = 1'b0;
		auto_factor = '0;
	end

	// hold the reading until taken, then scramble the released line
	task automatic send(input logic [`READING_W-1:0] v, input int gap);
		repeat (gap + 1) @(posedge aclk);
		reading_valid <= 1'b1;
		reading <= v;
		@(posedge aclk);
		while (reading_ready !== 1'b1) @(posedge aclk);
		reading_valid <= 1'b0;
		reading <= ~v;
	endtask : send

	task automatic pulse(input logic [`FACTOR_W-1:0] f);
		@(posedge aclk);
		auto_factor_valid <= 1'b1;
		auto_factor <= f;
		@(posedge aclk);
		auto_factor_valid <= 1'b0;
		auto_factor <= ~f;
	endtask : pulse
endmodule : front_end_model

/* File: verif/power_average_correction_tb_top.sv */
`timescale 1ns/100ps
`include "power_avg_regs.svh"
module power_average_correction_tb_top
	import power_avg_pkg::*;
;
	logic                  aclk, aresetn;
	logic                  awvalid, wvalid, bready, arvalid, rready;
	logic                  awready, wready, bvalid, arready, rvalid;
	logic [7:0]            awaddr, araddr;
	logic [31:0]           wdata, rdata;
	logic [1:0]            bresp, rresp;
	logic [3:0]            wstrb;
	logic [2:0]            prot;
	logic                  reading_valid, reading_ready, auto_factor_valid;
	logic                  est_noise_ratio_criterion, result_valid;
	logic [`READING_W-1:0] reading;
	logic [`FACTOR_W-1:0]  auto_factor;
	logic [2:0]            est_digits;
	logic [19:0]           est_noise_ratio_ppm;
	result_t               result;
	int                    n_fail, tests_run, cycles, seed;
	int                    m_factor, m_cnt, m_dterm, m_ofs;
	bit                    m_avg, m_run, m_den, m_oen;
	logic [31:0]           m_freq;
	longint                hist[$];
	longint                exp_pow[$];
	int                    exp_len[$];
	localparam logic [7:0]  RA [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
	localparam logic [31:0] RV [9] = '{1, 4, 400, 10000, 3, 1000, 0, 10000000, 0};

	power_average_correction power_average_correction_i (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_awprot(prot), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(prot),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .reading_valid(reading_valid),
		.reading_ready(reading_ready), .reading(reading),
		.auto_factor_valid(auto_factor_valid), .auto_factor(auto_factor),
		.est_noise_ratio_criterion(est_noise_ratio_criterion),
		.est_digits(est_digits), .est_noise_ratio_ppm(est_noise_ratio_ppm),
		.result_valid(result_valid), .result(result));

	front_end_model fe (
		.aclk(aclk), .reading_ready(reading_ready), .reading_valid(reading_valid),
		.reading(reading), .auto_factor_valid(auto_factor_valid),
		.auto_factor(auto_factor));

	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	task print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	always @(posedge aclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			n_fail++;
			print_verdict();
		end
	end

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		prot <= 3'($random(seed));
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask : axi_write

	task automatic chk_reg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		prot <= 3'($random(seed));
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		chk(rdata, e, "rdata");
		chk(32'(rresp), 32'(er), "rresp");
		rready <= 1'b0;
		@(posedge aclk);
	endtask : chk_reg

	task automatic filt_reset;
		hist.delete();
		m_cnt = 0;
	endtask : filt_reset

	task automatic wr(input logic [7:0] a, input int d, input logic [1:0] er);
		logic [1:0] r;
		int         x;
		axi_write(a, d, r);
		chk(32'(r), 32'(er), "bresp");
		if (er != 2'h0) return;
		if (a == 8'h00) {m_oen, m_den, m_run, m_avg} = {d[6], d[5], d[4], d[0]};
		if (a == 8'h04) m_factor = (d < 1) ? 1 : (d > 65536) ? 65536 : d;
		if (a == 8'h18) m_ofs = 32'(signed'(d[15:0]));
		if (a == 8'h1c) m_freq = d;
		// duty term is exact only at whole octaves below 100 percent
		if (a == 8'h14) m_dterm = 0;
		for (x = (d < 1) ? 1 : d; a == 8'h14 && x < 100000; x = x * 2) m_dterm += 301;
		if (a == 8'h00 || a == 8'h04 || (a == 8'h20 && d[0])) filt_reset();
	endtask : wr

	task automatic model_take(input longint v);
		longint s;
		if (!m_avg)
		begin
			exp_pow.push_back(v);
			exp_len.push_back(-1);
		end
		else
		begin
			hist.push_back(v);
			if (hist.size() > m_factor) void'(hist.pop_front());
			m_cnt++;
			if (m_run || m_cnt == m_factor)
			begin
				s = 0;
				foreach (hist[i]) s += hist[i];
				exp_pow.push_back(s / hist.size());
				exp_len.push_back(hist.size());
				m_cnt = 0;
			end
		end
	endtask : model_take

	always @(posedge aclk)
		if (aresetn && reading_valid && reading_ready) model_take(reading);

	always @(posedge aclk)
		if (result_valid === 1'b1)
		begin
			if (exp_pow.size() == 0)
				chk(32'h1, 32'h0, "unexpected result");
			else
			begin
				chk(32'(result.power), 32'(exp_pow.pop_front()), "power");
				if (exp_len[0] >= 0) chk(32'(result.length), exp_len[0], "length");
				void'(exp_len.pop_front());
				chk(32'(result.corr_cdb), (m_den ? m_dterm : 0) + (m_oen ? m_ofs : 0), "corr");
				chk(result.freq_khz, m_freq, "freq");
			end
		end

	task automatic feed(input int n);
		logic [31:0] rv;
		repeat (n)
		begin
			rv = $random(seed);
			fe.send(rv[23:0], rv[25:24]);
		end
		// let the model log the last take before looking at the queue
		@(posedge aclk);
		while (exp_pow.size() != 0) @(posedge aclk);
	endtask : feed

	initial
	begin
		seed = 32'hf3919dda;
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = 4'hf;
		prot = 3'h0;
		{n_fail, tests_run, cycles, m_cnt, m_dterm, m_ofs} = '0;
		{m_avg, m_run, m_den, m_oen} = 4'h8;
		m_factor = 4;
		m_freq = 32'd10000000;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(32'(est_digits), 3, "digits");
		chk(32'(est_noise_ratio_criterion), 0, "criterion");
		chk(32'(est_noise_ratio_ppm), 10000, "ratio");
		for (int i = 0; i < 9; i++) chk_reg(RA[i], RV[i], 2'h0);
		chk_reg(8'h28, 0, 2'h2);
		wr(8'h2c, 1, 2'h2);
		wr(8'h04, 70000, 2'h0);
		chk_reg(8'h04, 65536, 2'h0);
		wr(8'h04, 0, 2'h0);
		chk_reg(8'h04, 1, 2'h0);
		wr(8'h04, 4, 2'h0);
		feed(9);
		wr(8'h00, 32'h11, 2'h0);
		feed(3);
		wr(8'h20, 1, 2'h0);
		feed(6);
		wr(8'h18, 32'hfe0c, 2'h0);
		wr(8'h14, 50000, 2'h0);
		wr(8'h1c, 123456, 2'h0);
		wr(8'h00, 32'h71, 2'h0);
		feed(3);
		wr(8'h14, 25000, 2'h0);
		wr(8'h18, 200, 2'h0);
		feed(2);
		wr(8'h00, 32'h51, 2'h0);
		feed(2);
		wr(8'h14, 0, 2'h0);
		chk_reg(8'h14, 1, 2'h0);
		wr(8'h00, 0, 2'h0);
		feed(3);
		wr(8'h00, 32'h03, 2'h0);
		fe.pulse(8);
		chk_reg(8'h04, 8, 2'h0);
		fe.pulse(6);
		chk_reg(8'h04, 6, 2'h0);
		wr(8'h00, 32'h05, 2'h0);
		fe.pulse(5);
		fe.pulse(7);
		chk_reg(8'h04, 5, 2'h0);
		chk_reg(8'h00, 1, 2'h0);
		wr(8'h00, 32'h01, 2'h0);
		chk_reg(8'h04, 5, 2'h0);
		m_factor = 5;
		feed(5);
		wr(8'h00, 32'h09, 2'h0);
		chk(32'(est_noise_ratio_criterion), 1, "criterion");
		wr(8'h10, 5, 2'h0);
		chk_reg(8'h10, 3, 2'h0);
		wr(8'h10, 1, 2'h0);
		chk(32'(est_digits), 1, "digits");
		wr(8'h0c, 100, 2'h0);
		chk(32'(est_noise_ratio_ppm), 100, "ratio");
		wr(8'h08, 2, 2'h0);
		wr(8'h00, 32'h0b, 2'h0);
		fe.pulse(50);
		chk_reg(8'h04, 2, 2'h0);
		wstrb <= 4'h1;
		wr(8'h1c, 32'h11, 2'h0);
		chk_reg(8'h1c, 32'h0001e211, 2'h0);
		print_verdict();
	end
endmodule : power_average_correction_tb_top
